// >>> hdl/opcp_top.sv
// top: command decoder, serial shifter and display state of the panel port
// assumes: byte and bit strobes already synchronous to clk, host keeps order
`timescale 1ns/1ps

module opcp_top (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire logic                  chip_select_n,
  input  wire logic                  register_select_line,
  input  wire logic                  byte_stb,
  input  wire logic [7:0]            byte_in,
  input  wire logic                  serial_bit_stb,
  input  wire logic                  serial_bit,
  output logic                       display_on,
  output opcp_pkg::opcp_cfg_type     cfg,
  output logic [6:0]                 column,
  output logic [6:0]                 i2c_address,
  output logic                       data_stb,
  output logic [7:0]                 data_byte,
  output logic [6:0]                 data_column
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  opcp_pkg::opcp_state_type state_q;
  opcp_pkg::opcp_state_type state_d;
  logic [6:0]               addr_q;
  logic                     serial_done;
  logic [7:0]               serial_byte;
  logic                     got_byte;
  logic [7:0]               rx_byte;

  assign serial_done = serial_bit_stb && !chip_select_n && state_q.bit_cnt == opcp_pkg::BIT_LAST;
  assign serial_byte = {state_q.shift[6:0], serial_bit};
  assign got_byte    = (byte_stb && !chip_select_n) || serial_done;
  assign rx_byte     = serial_done ? serial_byte : byte_in;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_d          = state_q;
    state_d.data_stb = 1'b0;
    if (serial_bit_stb && !chip_select_n) begin
      state_d.shift   = serial_byte;
      state_d.bit_cnt = state_q.bit_cnt + 3'h1;
    end
    if (chip_select_n) begin
      state_d.bit_cnt = 3'h0;
    end
    if (got_byte && register_select_line) begin
      state_d.data_stb = 1'b1;
      state_d.data     = rx_byte;
      state_d.data_col = state_q.col;
      state_d.col      = (state_q.col == opcp_pkg::COL_LAST) ? 7'h00 : state_q.col + 7'h01;
    end else if (got_byte) begin
      unique case (state_q.arg)
        opcp_pkg::ARG_CONTRAST: state_d.cfg.contrast  = rx_byte;
        opcp_pkg::ARG_MUX:      state_d.cfg.mux_ratio = rx_byte[5:0];
        opcp_pkg::ARG_CLKDIV:   state_d.cfg.clk_div   = rx_byte;
        opcp_pkg::ARG_COMPIN:   state_d.cfg.com_pins  = rx_byte;
        opcp_pkg::ARG_OFFSET:   state_d.cfg.offset    = rx_byte[5:0];
        opcp_pkg::ARG_NONE: begin
          if (rx_byte[7:4] == opcp_pkg::GRP_COL_LO) begin
            state_d.col[3:0] = rx_byte[3:0];
          end else if (rx_byte[7:4] == opcp_pkg::GRP_COL_HI) begin
            state_d.col[6:4] = rx_byte[2:0];
          end else if (rx_byte[7:6] == opcp_pkg::GRP_START) begin
            state_d.cfg.start_line = rx_byte[5:0];
          end else begin
            unique case (rx_byte)
              opcp_pkg::CMD_OFF:       state_d.cfg.display_on = 1'b0;
              opcp_pkg::CMD_ON:        state_d.cfg.display_on = 1'b1;
              opcp_pkg::CMD_CONTRAST:  state_d.arg = opcp_pkg::ARG_CONTRAST;
              opcp_pkg::CMD_MUX:       state_d.arg = opcp_pkg::ARG_MUX;
              opcp_pkg::CMD_CLKDIV:    state_d.arg = opcp_pkg::ARG_CLKDIV;
              opcp_pkg::CMD_COMPIN:    state_d.arg = opcp_pkg::ARG_COMPIN;
              opcp_pkg::CMD_OFFSET:    state_d.arg = opcp_pkg::ARG_OFFSET;
              opcp_pkg::CMD_SEG_NORM:  state_d.cfg.seg_remap = 1'b0;
              opcp_pkg::CMD_SEG_REMAP: state_d.cfg.seg_remap = 1'b1;
              opcp_pkg::CMD_RESUME:    state_d.cfg.entire_on = 1'b0;
              opcp_pkg::CMD_ALL_ON:    state_d.cfg.entire_on = 1'b1;
              opcp_pkg::CMD_NORMAL:    state_d.cfg.inverse = 1'b0;
              opcp_pkg::CMD_INVERSE:   state_d.cfg.inverse = 1'b1;
              opcp_pkg::CMD_SCAN_NORM: state_d.cfg.scan_rev = 1'b0;
              opcp_pkg::CMD_SCAN_REV:  state_d.cfg.scan_rev = 1'b1;
              default: ;
            endcase
          end
        end
        default: state_d.arg = opcp_pkg::ARG_NONE;
      endcase
      if (state_q.arg != opcp_pkg::ARG_NONE) begin
        state_d.arg = opcp_pkg::ARG_NONE;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q.cfg.display_on <= 1'b0;
      state_q.cfg.mux_ratio  <= opcp_pkg::MUX_RST;
      state_q.cfg.seg_remap  <= 1'b0;
      state_q.cfg.scan_rev   <= 1'b0;
      state_q.shift          <= 8'h00;
      state_q.bit_cnt        <= 3'h0;
      state_q.cfg.start_line <= opcp_pkg::START_RST;
      state_q.col            <= opcp_pkg::COL_RST;
      state_q.cfg.contrast   <= opcp_pkg::CONTRAST_RST;
      state_q.cfg.entire_on  <= 1'b0;
      state_q.cfg.inverse    <= 1'b0;
      state_q.cfg.offset     <= opcp_pkg::OFFSET_RST;
      state_q.cfg.clk_div    <= opcp_pkg::CLKDIV_RST;
      state_q.cfg.com_pins   <= opcp_pkg::COMPIN_RST;
      state_q.arg            <= opcp_pkg::ARG_NONE;
      state_q.data_stb       <= 1'b0;
      state_q.data           <= 8'h00;
      state_q.data_col       <= 7'h00;
      addr_q                 <= opcp_pkg::I2C_ADDR_LOW;
    end else if (clk_en) begin
      state_q <= state_d;
      addr_q  <= register_select_line ? opcp_pkg::I2C_ADDR_HIGH : opcp_pkg::I2C_ADDR_LOW;
    end
  end

  assign display_on  = state_q.cfg.display_on;
  assign cfg         = state_q.cfg;
  assign column      = state_q.col;
  assign i2c_address = addr_q;
  assign data_stb    = state_q.data_stb;
  assign data_byte   = state_q.data;
  assign data_column = state_q.data_col;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_reset_display_off: assert property ($rose(reset_n) |-> !display_on && cfg.mux_ratio == 6'h3F)
    else $error("display not off after reset");
  a_reset_map_normal: assert property ($rose(reset_n) |-> !cfg.seg_remap && !cfg.scan_rev)
    else $error("mapping not normal after reset");
  a_reset_shift_clear: assert property ($rose(reset_n) |-> state_q.bit_cnt == 3'h0)
    else $error("shift count not cleared");
  a_reset_start_col: assert property ($rose(reset_n) |-> cfg.start_line == 6'h00 && column == 7'h00)
    else $error("start line or column not zero");
  a_reset_contrast: assert property ($rose(reset_n) |-> cfg.contrast == 8'h7F)
    else $error("contrast not 7Fh");
  a_reset_normal_mode: assert property ($rose(reset_n) |-> !cfg.entire_on && !cfg.inverse)
    else $error("display mode not normal");
  a_addr_select: assert property (clk_en |=> i2c_address == ($past(register_select_line) ? 7'h3D : 7'h3C))
    else $error("wrong bus address");
  a_cmd_off: assert property (clk_en && got_byte && !register_select_line && state_q.arg == opcp_pkg::ARG_NONE && rx_byte == 8'hAE |=> !display_on)
    else $error("off command ignored");
  a_cmd_on: assert property (clk_en && got_byte && !register_select_line && state_q.arg == opcp_pkg::ARG_NONE && rx_byte == 8'hAF |=> display_on)
    else $error("on command ignored");
  a_contrast_arg: assert property (clk_en && got_byte && !register_select_line && state_q.arg == opcp_pkg::ARG_CONTRAST |=> cfg.contrast == $past(rx_byte))
    else $error("contrast argument not loaded");
  a_data_strobe: assert property (clk_en && got_byte && register_select_line |=> data_stb && data_byte == $past(rx_byte))
    else $error("data byte not passed");
  a_mux_arg: assert property (clk_en && got_byte && !register_select_line && state_q.arg == opcp_pkg::ARG_MUX |=> cfg.mux_ratio == $past(rx_byte[5:0]))
    else $error("mux argument not loaded");
  a_start_line: assert property (clk_en && got_byte && !register_select_line && state_q.arg == opcp_pkg::ARG_NONE && rx_byte[7:6] == 2'h1 |=> cfg.start_line == $past(rx_byte[5:0]))
    else $error("start line not set");
  a_seg_remap: assert property (clk_en && got_byte && !register_select_line && state_q.arg == opcp_pkg::ARG_NONE && rx_byte == 8'hA1 |=> cfg.seg_remap)
    else $error("segment remap ignored");
  a_col_low: assert property (clk_en && got_byte && !register_select_line && state_q.arg == opcp_pkg::ARG_NONE && rx_byte[7:4] == 4'h0 |=> column[3:0] == $past(rx_byte[3:0]))
    else $error("column low nibble not set");

  c_display_on: cover property (got_byte ##[1:50] display_on);
  c_contrast_set: cover property (state_q.arg == opcp_pkg::ARG_CONTRAST ##1 state_q.arg == opcp_pkg::ARG_NONE);
  c_serial_byte: cover property (serial_done);
  c_data_write: cover property (data_stb);

endmodule : opcp_top

// >>> hdl/opcp_pkg.sv
// package: constants, states and carriers for the oled panel command port
// assumes: single clock domain, used by opcp_top and the bench
package opcp_pkg;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CONTRAST_RST  = 8'h7F;
  localparam logic [5:0] MUX_RST       = 6'h3F;
  localparam logic [5:0] START_RST     = 6'h00;
  localparam logic [5:0] OFFSET_RST    = 6'h00;
  localparam logic [7:0] CLKDIV_RST    = 8'h80;
  localparam logic [7:0] COMPIN_RST    = 8'h12;
  localparam logic [6:0] COL_RST       = 7'h00;

  // ----------------------------------------
  // bus addresses
  // ----------------------------------------
  localparam logic [6:0] I2C_ADDR_LOW  = 7'h3C;
  localparam logic [6:0] I2C_ADDR_HIGH = 7'h3D;

  // ----------------------------------------
  // command codes, group prefixes and counter limits
  // ----------------------------------------
  localparam logic [7:0] CMD_OFF       = 8'hAE;
  localparam logic [7:0] CMD_ON        = 8'hAF;
  localparam logic [7:0] CMD_CONTRAST  = 8'h81;
  localparam logic [7:0] CMD_MUX       = 8'hA8;
  localparam logic [7:0] CMD_CLKDIV    = 8'hD5;
  localparam logic [7:0] CMD_COMPIN    = 8'hDA;
  localparam logic [7:0] CMD_OFFSET    = 8'hD3;
  localparam logic [7:0] CMD_SEG_NORM  = 8'hA0;
  localparam logic [7:0] CMD_SEG_REMAP = 8'hA1;
  localparam logic [7:0] CMD_RESUME    = 8'hA4;
  localparam logic [7:0] CMD_ALL_ON    = 8'hA5;
  localparam logic [7:0] CMD_NORMAL    = 8'hA6;
  localparam logic [7:0] CMD_INVERSE   = 8'hA7;
  localparam logic [7:0] CMD_SCAN_NORM = 8'hC0;
  localparam logic [7:0] CMD_SCAN_REV  = 8'hC8;
  localparam logic [3:0] GRP_COL_LO    = 4'h0;
  localparam logic [3:0] GRP_COL_HI    = 4'h1;
  localparam logic [1:0] GRP_START     = 2'h1;
  localparam logic [6:0] COL_LAST      = 7'h7F;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ARG_NONE, ARG_CONTRAST, ARG_MUX, ARG_CLKDIV, ARG_COMPIN, ARG_OFFSET
  } opcp_arg_type;

  typedef struct packed {
    logic       display_on;
    logic       seg_remap;
    logic       scan_rev;
    logic       entire_on;
    logic       inverse;
    logic [7:0] contrast;
    logic [5:0] mux_ratio;
    logic [5:0] start_line;
    logic [5:0] offset;
    logic [7:0] clk_div;
    logic [7:0] com_pins;
  } opcp_cfg_type;

  typedef struct packed {
    opcp_cfg_type cfg;
    opcp_arg_type arg;
    logic [6:0]   col;
    logic [7:0]   shift;
    logic [2:0]   bit_cnt;
    logic         data_stb;
    logic [7:0]   data;
    logic [6:0]   data_col;
  } opcp_state_type;

endpackage : opcp_pkg

// >>> tb/opcp_host.sv
// host model: writes command and data bytes into the panel port
// assumes: bench calls one task at a time, tasks start off the clock edge
`timescale 1ns/1ps

module opcp_host (
  input  wire logic       clk,
  output logic            chip_select_n,
  output logic            register_select_line,
  output logic            byte_stb,
  output logic [7:0]      byte_in,
  output logic            serial_bit_stb,
  output logic            serial_bit
);
  initial begin
    chip_select_n        = 1'b1;
    register_select_line = 1'b0;
    byte_stb             = 1'b0;
    byte_in              = 8'hA5;
    serial_bit_stb       = 1'b0;
    serial_bit           = 1'b0;
  end

  // ----------------------------------------
  // byte write, parallel or serial msb first
  // ----------------------------------------
  task automatic put(input logic rs, input logic [7:0] b, input bit ser, input logic cs_n);
    @(posedge clk);
    chip_select_n        <= cs_n;
    register_select_line <= rs;
    if (ser) begin
      for (int i = 7; i >= 0; i--) begin
        serial_bit_stb <= 1'b1;
        serial_bit     <= b[i];
        @(posedge clk);
      end
    end else begin
      byte_stb <= 1'b1;
      byte_in  <= b;
      @(posedge clk);
    end
    byte_stb       <= 1'b0;
    serial_bit_stb <= 1'b0;
    byte_in        <= ~b;
    serial_bit     <= ~b[0];
  endtask : put

  // partial serial byte, then select released
  task automatic part(input int n);
    @(posedge clk);
    chip_select_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_bit_stb <= 1'b1;
      serial_bit     <= 1'($urandom);
      @(posedge clk);
    end
    serial_bit_stb <= 1'b0;
    chip_select_n  <= 1'b1;
  endtask : part
endmodule : opcp_host

// >>> tb/testbench.sv
// bench: host model plus reference model compared with the panel port
// assumes: opcp_pkg and opcp_top compiled first
`timescale 1ns/1ps

module testbench;
  logic                   clk, reset_n, clk_en, cs_n, rs, bstb, sstb, sbit;
  logic [7:0]             bin, d, dbyte;
  logic [6:0]             column, addr, dcol;
  logic                   on, dstb;
  opcp_pkg::opcp_cfg_type cfg, m;
  int                     fails, compares, col, arg;
  logic [7:0]             seq [25] = '{8'hAE, 8'h00, 8'h10, 8'h40, 8'h81, 8'h00, 8'hA1,
    8'hA6, 8'hA8, 8'h3F, 8'hC8, 8'hD3, 8'h00, 8'hD5, 8'h80, 8'hDA, 8'h12, 8'hA5,
    8'hA7, 8'hA4, 8'hA6, 8'h4B, 8'h0F, 8'h17, 8'hAF};

  opcp_host i_host (.clk(clk), .chip_select_n(cs_n), .register_select_line(rs),
    .byte_stb(bstb), .byte_in(bin), .serial_bit_stb(sstb), .serial_bit(sbit));
  opcp_top i_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .chip_select_n(cs_n),
    .register_select_line(rs), .byte_stb(bstb), .byte_in(bin), .serial_bit_stb(sstb),
    .serial_bit(sbit), .display_on(on), .cfg(cfg), .column(column), .i2c_address(addr),
    .data_stb(dstb), .data_byte(dbyte), .data_column(dcol));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // reference model and compares
  // ----------------------------------------
  task automatic mdl(input logic [7:0] b);
    if (arg != 0) begin
      case (arg)
        1: m.contrast = b;
        2: m.mux_ratio = b[5:0];
        3: m.clk_div = b;
        4: m.com_pins = b;
        default: m.offset = b[5:0];
      endcase
      arg = 0;
    end else if (b < 8'h10) col = (col & 8'h70) | b;
    else if (b < 8'h20) col = (col & 8'h0F) | ((b & 8'h07) << 4);
    else if (b >= 8'h40 && b < 8'h80) m.start_line = b[5:0];
    else case (b)
      8'hAE: m.display_on = 1'b0;
      8'hAF: m.display_on = 1'b1;
      8'h81: arg = 1;
      8'hA8: arg = 2;
      8'hD5: arg = 3;
      8'hDA: arg = 4;
      8'hD3: arg = 5;
      8'hA0, 8'hA1: m.seg_remap = b[0];
      8'hA4, 8'hA5: m.entire_on = b[0];
      8'hA6, 8'hA7: m.inverse = b[0];
      8'hC0, 8'hC8: m.scan_rev = b[3];
      default: ;
    endcase
  endtask : mdl

  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  task automatic chk;
    cmp(64'(cfg), 64'(m));
    cmp(64'(on), 64'(m.display_on));
    cmp(64'(column), 64'(col));
  endtask : chk

  task automatic rst;
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    m = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h7F, 6'h3F, 6'h00, 6'h00, 8'h80, 8'h12};
    col = 0;
    arg = 0;
    #1;
  endtask : rst

  task automatic cmd(input logic [7:0] b, input bit ser);
    i_host.put(1'b0, b, ser, 1'b0);
    mdl(b);
    #1 chk;
  endtask : cmd

  task automatic close_out;
    $display("counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    close_out;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(10113));
    reset_n = 1'b0;
    clk_en  = 1'b1;
    rst;
    chk;
    cmp(64'(addr), 64'(7'h3C));
    $display("test reset done");
    seq[5] = 8'($urandom);
    for (int i = 0; i < 25; i++) cmd(seq[i], i[0]);
    $display("test init done");
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      i_host.put(1'b1, d, i[0], 1'b0);
      #1 cmp(64'({dstb, dbyte, dcol}), 64'({1'b1, d, 7'(col)}));
      col = (col + 1) & 8'h7F;
    end
    @(posedge clk);
    #1 cmp(64'({dstb, addr}), 64'({1'b0, 7'h3D}));
    chk;
    $display("test data done");
    clk_en <= 1'b0;
    i_host.put(1'b0, 8'hAE, 1'b0, 1'b0);
    clk_en <= 1'b1;
    #1 chk;
    i_host.put(1'b0, 8'hAE, 1'b0, 1'b1);
    #1 chk;
    i_host.part(3);
    cmd(8'hAE, 1'b1);
    i_host.part(5);
    rst;
    chk;
    cmd(8'hAF, 1'b1);
    cmd(8'hAE, 1'b0);
    $display("test refuse and drop done");
    close_out;
  end
endmodule : testbench
